// >>> logic/bus_state_logic.sv
// memory timing configuration and refresh engine of the bus state logic
//
// Behaviour
// - SDRAM row phase puts A9, A10 or A11 on line A1 per select field.
// - refresh_on at 0 means no refresh; reset value 0.
// - refresh_on 1, kind 0: periodic refresh at timer compare period.
// - periodic refresh during a bus cycle ends the cycle in the same clock as refresh RAS rises.
// - kind 1: wait for bus cycle end, then enter self-refresh.
// - refresh requests are ignored while memory is in self-refresh.
// - EDO select picks rising-edge sampling and half-cycle late RAS off.
// - DRAM on area 2 fixes that area's bus width at 16 bits.
// - area-2 register resets to zero; software initialises it first.
// - area-2 precharge code gives 1 to 4 cycles, default 1.
// - area-2 row-to-column delay 1 to 4; ignored under extended timing.
// - area-2 refresh RAS assert code gives 2 to 5 cycles.
// - area-2 multiplex code gives 8 to 11 column bits, default 8.
// - area-2 bits 11, 10, 7, 5, 0 ignore writes and read zero.
// - four-bit PC card wait code maps to first and burst wait counts.
// - PC card strobe assert delay 0.5 to 7.5 cycles per code.
// - PC card address hold after strobe 0.5 to 7.5 cycles per code.
// - mode value travels on address, shifted by two or one bit.
// - timer control writes take effect only with key A5 in upper byte.
// - timer control resets to zero; upper byte reads zero.
// - compare flag clears on refresh after zero written, periodic mode.
// - timer counts, on match sets compare flag and clears; 1 ignored.
// - compare interrupt enable raises request while flag is set.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module bus_state_logic
   import refresh_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic bus_cycle_active,
   input wire logic [2:0] row_source_bits,
   input wire logic area2_is_dram,
   output logic [15:0] reg_rdata,
   output logic row_a1,
   output logic bus_terminate,
   output logic refresh_ras,
   output logic self_refresh,
   output logic sample_on_rise,
   output logic ras_negate_late,
   output logic area2_bus16,
   output logic [2:0] area2_precharge_cycles,
   output logic [2:0] area2_row_col_cycles,
   output logic [3:0] area2_col_bits,
   output logic [5:0] area5_first_waits,
   output logic [5:0] area5_burst_states,
   output logic [5:0] area6_first_waits,
   output logic [5:0] area6_burst_states,
   output logic [3:0] area5_lead_half,
   output logic [3:0] area5_trail_half,
   output logic [3:0] area6_lead_half,
   output logic [3:0] area6_trail_half,
   output logic mode_write,
   output logic [11:0] mode_value,
   output logic timer_irq
);
   // ==========================================================
   // decoding helpers
   function automatic logic [5:0] first_waits(input logic [3:0] code);
      logic [5:0] w;
      w = 6'h00;
      unique case (code)
         4'h0: w = 6'h00;
         4'h1: w = 6'h01;
         4'h2: w = 6'h02;
         4'h3: w = 6'h03;
         4'h4: w = 6'h04;
         4'h5: w = 6'h06;
         4'h6: w = 6'h08;
         4'h7: w = 6'h0A;
         4'h8: w = 6'h0C;
         4'h9: w = 6'h0E;
         4'hA: w = 6'h12;
         4'hB: w = 6'h16;
         4'hC: w = 6'h1A;
         4'hD: w = 6'h1E;
         4'hE: w = 6'h22;
         4'hF: w = 6'h26;
      endcase
      return w;
   endfunction

   function automatic logic [5:0] burst_states(input logic [3:0] code);
      logic [5:0] b;
      b = (code == 4'h0) ? 6'h02 : 6'(first_waits(code) + 6'h01);
      return b;
   endfunction

   // half-cycle count, always odd: code n gives n + 0.5 cycles
   function automatic logic [3:0] half_steps(input logic [2:0] code);
      logic [3:0] h;
      h = {code, 1'b1};
      return h;
   endfunction

   // mask of prescaler bits that must all be set for one timer tick
   function automatic logic [11:0] tick_mask(input logic [2:0] sel);
      logic [11:0] m;
      m = 12'h000;
      unique case (sel)
         3'h0: m = 12'h000;
         3'h1: m = 12'h003;
         3'h2: m = 12'h00F;
         3'h3: m = 12'h03F;
         3'h4: m = 12'h0FF;
         3'h5: m = 12'h3FF;
         3'h6: m = 12'h7FF;
         3'h7: m = 12'hFFF;
      endcase
      return m;
   endfunction

   // ==========================================================
   // registers
   logic [15:0] memory_control;
   logic [15:0] area2_dram_control;
   logic [15:0] pc_card_timing_control;
   logic [6:0] timer_ctrl;
   logic compare_match_flag;
   logic flag_clear_armed;
   logic [7:0] refresh_timer_counter;
   logic [7:0] refresh_time_constant;
   logic [9:0] refresh_event_counter;
   logic [11:0] prescale;
   logic [1:0] bus_config;
   logic [5:0] pc_card_wait_low;
   logic req_pending;
   logic [2:0] phase_count;
   refresh_state_t state;
   refresh_state_t next_state;

   // ==========================================================
   // register decode
   wire keyed = reg_wdata[15:8] == TIMER_WRITE_KEY;
   wire wr_mem = reg_write && reg_addr == ADDR_MEMORY_CONTROL;
   wire wr_area2 = reg_write && reg_addr == ADDR_AREA2_DRAM_CONTROL;
   wire wr_pcc = reg_write && reg_addr == ADDR_PC_CARD_TIMING;
   wire wr_csr = reg_write && keyed && reg_addr == ADDR_REFRESH_TIMER_CSR;
   wire wr_cnt = reg_write && keyed &&
      reg_addr == ADDR_REFRESH_TIMER_COUNTER;
   wire wr_const = reg_write && keyed &&
      reg_addr == ADDR_REFRESH_TIME_CONSTANT;
   wire wr_cfg = reg_write && reg_addr == ADDR_BUS_CONFIG;
   wire wr_wait = reg_write && reg_addr == ADDR_PC_CARD_WAIT_LOW;
   wire wr_mode = reg_write && reg_addr[15:12] == SDRAM_MODE_WINDOW &&
      reg_addr[1:0] == 2'b00;

   wire refresh_on = memory_control[REFRESH_ON_BIT] ||
      area2_dram_control[REFRESH_ON_BIT];
   wire refresh_kind_select = memory_control[KIND_BIT] ||
      area2_dram_control[KIND_BIT];
   wire periodic = refresh_on && !refresh_kind_select;
   wire self_mode = refresh_on && refresh_kind_select;
   wire [2:0] row_shift_select = memory_control[ROW_SHIFT_LO+:3];
   wire [2:0] cks = timer_ctrl[CSR_CKS_LO+:3];
   wire [11:0] cur_mask = tick_mask(cks);
   wire tick = cks != 3'h0 && (prescale & cur_mask) == cur_mask;
   wire timer_match = tick && refresh_timer_counter == refresh_time_constant;
   wire [9:0] event_limit = timer_ctrl[CSR_LIMIT_BIT] ?
      EVENT_LIMIT_SHORT : EVENT_LIMIT_LONG;
   wire event_over = timer_match && refresh_event_counter == event_limit;
   wire refresh_start = state == ST_IDLE && next_state == ST_RAS;
   wire [2:0] ras_len = 3'(area2_dram_control[AREA2_RAS_LO+:2]) +
      LEAST_RAS_ASSERT;
   wire [2:0] pre_len = 3'(area2_dram_control[AREA2_PRECHARGE_LO+:2]) + 3'h1;
   wire [3:0] a5_code = {pc_card_timing_control[14], pc_card_wait_low[2:0]};
   wire [3:0] a6_code = {pc_card_timing_control[15], pc_card_wait_low[5:3]};
   wire [15:0] csr_view = {8'h00, compare_match_flag, timer_ctrl};
   wire flag_write_zero = wr_csr && !reg_wdata[CSR_MATCH_FLAG_BIT];
   wire next_match_flag = timer_match ||
      (compare_match_flag && !(flag_clear_armed && refresh_start &&
      periodic) && !(flag_write_zero && !periodic));
   wire [15:0] next_rdata =
      reg_addr == ADDR_MEMORY_CONTROL ? memory_control :
      reg_addr == ADDR_AREA2_DRAM_CONTROL ? area2_dram_control :
      reg_addr == ADDR_PC_CARD_TIMING ? pc_card_timing_control :
      reg_addr == ADDR_REFRESH_TIMER_CSR ? csr_view :
      reg_addr == ADDR_REFRESH_TIMER_COUNTER ?
      {8'h00, refresh_timer_counter} :
      reg_addr == ADDR_REFRESH_TIME_CONSTANT ?
      {8'h00, refresh_time_constant} :
      reg_addr == ADDR_REFRESH_EVENT_COUNTER ?
      {6'h00, refresh_event_counter} :
      reg_addr == ADDR_BUS_CONFIG ? {14'h0000, bus_config} :
      reg_addr == ADDR_PC_CARD_WAIT_LOW ? {10'h000, pc_card_wait_low} :
      reg_addr == ADDR_ENGINE_STATUS ? {13'h0000, state} : 16'h0000;
   wire next_row_a1 = row_shift_select == 3'h1 || row_shift_select == 3'h5 ?
      row_source_bits[1] :
      row_shift_select == 3'h2 || row_shift_select == 3'h7 ?
      row_source_bits[2] : row_source_bits[0];

   // ==========================================================
   // register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         memory_control <= MEMORY_CONTROL_RESET;
         area2_dram_control <= AREA2_DRAM_RESET;
         pc_card_timing_control <= PC_CARD_TIMING_RESET;
         timer_ctrl <= REFRESH_CSR_RESET[6:0];
         bus_config <= BUS_CONFIG_RESET;
         pc_card_wait_low <= PC_CARD_WAIT_LOW_RESET;
         refresh_time_constant <= 8'h00;
      end else begin
         if (wr_mem)
            memory_control <= reg_wdata;
         if (wr_area2)
            area2_dram_control <= reg_wdata & AREA2_WRITABLE_MASK;
         if (wr_pcc)
            pc_card_timing_control <= reg_wdata;
         if (wr_csr) begin
            timer_ctrl[CSR_MATCH_IRQ_BIT:CSR_CKS_LO] <=
               reg_wdata[CSR_MATCH_IRQ_BIT:CSR_CKS_LO];
            timer_ctrl[CSR_OVER_IRQ_BIT] <= reg_wdata[CSR_OVER_IRQ_BIT];
            timer_ctrl[CSR_LIMIT_BIT] <= reg_wdata[CSR_LIMIT_BIT];
         end
         // overflow: set wins, writing one leaves it
         timer_ctrl[CSR_OVER_FLAG_BIT] <= event_over ||
            (timer_ctrl[CSR_OVER_FLAG_BIT] && !(wr_csr &&
            !reg_wdata[CSR_OVER_FLAG_BIT]));
         if (wr_const)
            refresh_time_constant <= reg_wdata[7:0];
         if (wr_cfg)
            bus_config <= reg_wdata[1:0];
         if (wr_wait)
            pc_card_wait_low <= reg_wdata[5:0];
      end
   end

   // ==========================================================
   // refresh timer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prescale <= 12'h000;
         refresh_timer_counter <= 8'h00;
         refresh_event_counter <= 10'h000;
         compare_match_flag <= 1'b0;
         flag_clear_armed <= 1'b0;
      end else begin
         prescale <= prescale + 12'h001;
         if (wr_cnt)
            refresh_timer_counter <= reg_wdata[7:0];
         else if (timer_match)
            refresh_timer_counter <= 8'h00;
         else if (tick)
            refresh_timer_counter <= refresh_timer_counter + 8'h01;
         if (event_over)
            refresh_event_counter <= 10'h000;
         else if (timer_match)
            refresh_event_counter <= refresh_event_counter + 10'h001;
         compare_match_flag <= next_match_flag;
         if (flag_write_zero)
            flag_clear_armed <= 1'b1;
         else if (refresh_start || !compare_match_flag)
            flag_clear_armed <= 1'b0;
      end
   end

   // ==========================================================
   // refresh engine
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (self_mode)
               next_state = ST_SELF_WAIT;
            else if (periodic && req_pending)
               next_state = ST_RAS;
         end
         ST_RAS: begin
            if (phase_count == 3'h1)
               next_state = ST_PRE;
         end
         ST_PRE: begin
            if (phase_count == 3'h1)
               next_state = ST_IDLE;
         end
         ST_SELF_WAIT: begin
            if (!self_mode)
               next_state = ST_IDLE;
            else if (!bus_cycle_active)
               next_state = ST_SELF;
         end
         ST_SELF: begin
            if (!self_mode)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         phase_count <= 3'h0;
         req_pending <= 1'b0;
      end else begin
         state <= next_state;
         if (refresh_start)
            phase_count <= ras_len;
         else if (state == ST_RAS && next_state == ST_PRE)
            phase_count <= pre_len;
         else if (phase_count != 3'h0)
            phase_count <= phase_count - 3'h1;
         if (!periodic || state == ST_SELF)
            req_pending <= 1'b0;
         else if (timer_match)
            req_pending <= 1'b1;
         else if (refresh_start)
            req_pending <= 1'b0;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         row_a1 <= 1'b0;
         bus_terminate <= 1'b0;
         refresh_ras <= 1'b0;
         self_refresh <= 1'b0;
         sample_on_rise <= 1'b0;
         ras_negate_late <= 1'b0;
         area2_bus16 <= 1'b0;
         area2_precharge_cycles <= 3'h1;
         area2_row_col_cycles <= 3'h1;
         area2_col_bits <= 4'h8;
         area5_first_waits <= 6'h00;
         area5_burst_states <= 6'h02;
         area6_first_waits <= 6'h00;
         area6_burst_states <= 6'h02;
         area5_lead_half <= 4'h1;
         area5_trail_half <= 4'h1;
         area6_lead_half <= 4'h1;
         area6_trail_half <= 4'h1;
         mode_write <= 1'b0;
         mode_value <= 12'h000;
         timer_irq <= 1'b0;
      end else begin
         reg_rdata <= reg_read ? next_rdata : 16'h0000;
         row_a1 <= next_row_a1;
         bus_terminate <= refresh_start && bus_cycle_active;
         refresh_ras <= next_state == ST_RAS;
         self_refresh <= next_state == ST_SELF;
         sample_on_rise <= memory_control[EDO_BIT];
         ras_negate_late <= memory_control[EDO_BIT];
         area2_bus16 <= area2_is_dram;
         area2_precharge_cycles <= pre_len;
         area2_row_col_cycles <= bus_config[CFG_EXTEND_BIT] ? 3'h0 :
            3'(area2_dram_control[AREA2_ROW_COL_LO+:2]) + 3'h1;
         area2_col_bits <= 4'(area2_dram_control[AREA2_COL_LO+:2]) +
            4'h8;
         area5_first_waits <= first_waits(a5_code);
         area5_burst_states <= burst_states(a5_code);
         area6_first_waits <= first_waits(a6_code);
         area6_burst_states <= burst_states(a6_code);
         area5_lead_half <= half_steps({pc_card_timing_control[11],
            pc_card_timing_control[7:6]});
         area6_lead_half <= half_steps({pc_card_timing_control[10],
            pc_card_timing_control[5:4]});
         area5_trail_half <= half_steps({pc_card_timing_control[9],
            pc_card_timing_control[3:2]});
         area6_trail_half <= half_steps({pc_card_timing_control[8],
            pc_card_timing_control[1:0]});
         mode_write <= wr_mode;
         if (wr_mode)
            mode_value <= bus_config[CFG_BUS32_BIT] ?
               {2'b00, reg_addr[11:2]} : {1'b0, reg_addr[11:1]};
         timer_irq <= next_match_flag &&
            timer_ctrl[CSR_MATCH_IRQ_BIT];
      end
   end

   // ==========================================================
   // checks
   property p_no_refresh_off;
      @(posedge clk) disable iff (sys_rst)
         (state == ST_IDLE && !refresh_on) |=> state != ST_RAS;
   endproperty
   a_no_refresh_off: assert property (p_no_refresh_off)
      else $error("refresh started while disabled");
   property p_periodic_start;
      @(posedge clk) disable iff (sys_rst)
         (state == ST_IDLE && periodic && req_pending) |=> refresh_ras;
   endproperty
   a_periodic_start: assert property (p_periodic_start)
      else $error("pending periodic refresh not started");
   property p_terminate;
      @(posedge clk) disable iff (sys_rst)
         (state == ST_IDLE && periodic && req_pending && bus_cycle_active)
         |=> bus_terminate ##1 !bus_terminate;
   endproperty
   a_terminate: assert property (p_terminate)
      else $error("bus cycle not ended for refresh");
   property p_self_waits;
      @(posedge clk) disable iff (sys_rst)
         (state == ST_SELF_WAIT && bus_cycle_active) |=> !self_refresh;
   endproperty
   a_self_waits: assert property (p_self_waits)
      else $error("self-refresh entered during bus cycle");
   property p_self_ignore;
      @(posedge clk) disable iff (sys_rst)
         state == ST_SELF |=> !refresh_ras && !req_pending;
   endproperty
   a_self_ignore: assert property (p_self_ignore)
      else $error("refresh request acted on in self-refresh");
   property p_ras_hold;
      @(posedge clk) disable iff (sys_rst)
         $rose(refresh_ras) |-> refresh_ras[*2];
   endproperty
   a_ras_hold: assert property (p_ras_hold)
      else $error("refresh RAS shorter than two cycles");
   property p_area2_reserved;
      @(posedge clk) disable iff (sys_rst)
         (area2_dram_control & ~AREA2_WRITABLE_MASK) == 16'h0000;
   endproperty
   a_area2_reserved: assert property (p_area2_reserved)
      else $error("area-2 reserved bit set");
   property p_key;
      @(posedge clk) disable iff (sys_rst)
         (reg_write && !keyed && reg_addr == ADDR_REFRESH_TIMER_CSR)
         |=> $stable({timer_ctrl[6:3], timer_ctrl[1:0]});
   endproperty
   a_key: assert property (p_key)
      else $error("unkeyed timer control write took effect");
   property p_match_sets;
      @(posedge clk) disable iff (sys_rst)
         timer_match |=> compare_match_flag && refresh_timer_counter == 8'h00;
   endproperty
   a_match_sets: assert property (p_match_sets)
      else $error("compare match not recorded");
   property p_irq;
      @(posedge clk) disable iff (sys_rst)
         (compare_match_flag && timer_ctrl[CSR_MATCH_IRQ_BIT])
         |-> ##[0:1] timer_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("compare interrupt missing");
endmodule

// >>> logic/refresh_ctrl_pkg.sv
// shared register map, field positions, reset values and codes
package refresh_ctrl_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [15:0] ADDR_MEMORY_CONTROL = 16'h0000;
   localparam logic [15:0] ADDR_AREA2_DRAM_CONTROL = 16'h0004;
   localparam logic [15:0] ADDR_PC_CARD_TIMING = 16'h0008;
   localparam logic [15:0] ADDR_REFRESH_TIMER_CSR = 16'h000C;
   localparam logic [15:0] ADDR_REFRESH_TIMER_COUNTER = 16'h0010;
   localparam logic [15:0] ADDR_REFRESH_TIME_CONSTANT = 16'h0014;
   localparam logic [15:0] ADDR_REFRESH_EVENT_COUNTER = 16'h0018;
   localparam logic [15:0] ADDR_BUS_CONFIG = 16'h001C;
   localparam logic [15:0] ADDR_PC_CARD_WAIT_LOW = 16'h0020;
   localparam logic [15:0] ADDR_ENGINE_STATUS = 16'h0024;
   // mode program window: base plus value, value below 16'h1000
   localparam logic [3:0] SDRAM_MODE_WINDOW = 4'h1;
   // ==========================================================
   // reset values
   localparam logic [15:0] MEMORY_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] AREA2_DRAM_RESET = 16'h0000;
   localparam logic [15:0] PC_CARD_TIMING_RESET = 16'h0000;
   localparam logic [7:0] REFRESH_CSR_RESET = 8'h00;
   localparam logic [5:0] PC_CARD_WAIT_LOW_RESET = 6'h3F;
   localparam logic [1:0] BUS_CONFIG_RESET = 2'h0;
   // ==========================================================
   // field positions
   localparam int EDO_BIT = 0;
   localparam int KIND_BIT = 1;
   localparam int REFRESH_ON_BIT = 2;
   localparam int ROW_SHIFT_LO = 3;
   localparam int AREA2_COL_LO = 3;
   localparam int AREA2_RAS_LO = 8;
   localparam int AREA2_ROW_COL_LO = 12;
   localparam int AREA2_PRECHARGE_LO = 14;
   localparam int CSR_MATCH_FLAG_BIT = 7;
   localparam int CSR_MATCH_IRQ_BIT = 6;
   localparam int CSR_CKS_LO = 3;
   localparam int CSR_OVER_FLAG_BIT = 2;
   localparam int CSR_OVER_IRQ_BIT = 1;
   localparam int CSR_LIMIT_BIT = 0;
   localparam int CFG_EXTEND_BIT = 0;
   localparam int CFG_BUS32_BIT = 1;
   localparam logic [15:0] AREA2_WRITABLE_MASK = 16'hF35E;
   // ==========================================================
   // write key and counts
   localparam logic [7:0] TIMER_WRITE_KEY = 8'hA5;
   localparam logic [9:0] EVENT_LIMIT_LONG = 10'h3FF;
   localparam logic [9:0] EVENT_LIMIT_SHORT = 10'h1FF;
   localparam logic [2:0] LEAST_RAS_ASSERT = 3'h2;
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RAS,
      ST_PRE,
      ST_SELF_WAIT,
      ST_SELF
   } refresh_state_t;
endpackage

// >>> testbench/memory_side_model.sv
// far-side model that owns the external bus cycle
`timescale 1ns/10ps
module memory_side_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic finish,
   input wire logic bus_terminate,
   output logic bus_cycle_active
);
   // ==========================================================
   // cycle runs until finished, or is cut short for a refresh
   always_ff @(posedge clk) begin
      if (sys_rst | finish | bus_terminate) begin
         bus_cycle_active <= 1'b0;
      end else if (start) begin
         bus_cycle_active <= 1'b1;
      end
   end
endmodule

// >>> testbench/tb_bus_state_logic.sv
// self-checking bench for the bus state logic
`timescale 1ns/10ps
module tb_bus_state_logic
   import refresh_ctrl_pkg::*;
();
   logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0;
   logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [2:0] row_source_bits = 0, pre_c, rc_c;
   logic area2_is_dram = 0, start = 0, finish = 0, bus_cycle_active;
   logic row_a1, bus_terminate, refresh_ras, self_refresh, timer_irq;
   logic sample_on_rise, ras_negate_late, area2_bus16, mode_write;
   logic [3:0] col_b, l5, t5, l6, t6;
   logic [5:0] f5, b5, f6, b6;
   logic [11:0] mode_value;
   logic [5:0] wait_tab [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
      6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h12, 6'h16, 6'h1A, 6'h1E,
      6'h22, 6'h26};
   int n_mismatch = 0, checks_done = 0;
   always #5 clk = ~clk;
   bus_state_logic DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .bus_cycle_active(bus_cycle_active), .row_source_bits(row_source_bits),
      .area2_is_dram(area2_is_dram), .reg_rdata(reg_rdata), .row_a1(row_a1),
      .bus_terminate(bus_terminate), .refresh_ras(refresh_ras),
      .self_refresh(self_refresh), .sample_on_rise(sample_on_rise),
      .ras_negate_late(ras_negate_late), .area2_bus16(area2_bus16),
      .area2_precharge_cycles(pre_c), .area2_row_col_cycles(rc_c),
      .area2_col_bits(col_b), .area5_first_waits(f5),
      .area5_burst_states(b5), .area6_first_waits(f6),
      .area6_burst_states(b6), .area5_lead_half(l5), .area5_trail_half(t5),
      .area6_lead_half(l6), .area6_trail_half(t6), .mode_write(mode_write),
      .mode_value(mode_value), .timer_irq(timer_irq));
   memory_side_model partner (.clk(clk), .sys_rst(sys_rst), .start(start),
      .finish(finish), .bus_terminate(bus_terminate),
      .bus_cycle_active(bus_cycle_active));
   // ==========================================================
   // shared tasks
   task automatic final_report();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [15:0] a, logic [15:0] exp, string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask
   task automatic wait_hi(ref logic s, input int lim, input string nm);
      for (int i = 0; i < lim && s !== 1'b1; i++) cyc(1);
      chk(nm, 16'h0001, 16'(s));
      if (s !== 1'b1) final_report();
   endtask
   task automatic quiet(int n, string nm);
      logic hit;
      hit = 0;
      repeat (n) begin
         cyc(1);
         if (refresh_ras === 1'b1) hit = 1;
      end
      chk(nm, 16'h0000, 16'(hit));
   endtask
   task automatic pulse(bit fin);
      @(posedge clk);
      if (fin)
         finish <= 1'b1;
      else
         start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      finish <= 1'b0;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      cyc(2);
      chk("pre", 16'h0001, 16'(pre_c));
      chk("col", 16'h0008, 16'(col_b));
      chk("first6", 16'h000A, 16'(f6));
      chk("burst5", 16'h000B, 16'(b5));
      rd(ADDR_AREA2_DRAM_CONTROL, 16'h0000, "area2");
      rd(ADDR_REFRESH_TIMER_CSR, 16'h0000, "csr");
      rd(16'h0040, 16'h0000, "unmapped");
   endtask
   task automatic t_regs();
      wr(ADDR_AREA2_DRAM_CONTROL, 16'hFFFF);
      rd(ADDR_AREA2_DRAM_CONTROL, 16'hF35E, "area2");
      cyc(1);
      chk("pre", 16'h0004, 16'(pre_c));
      chk("rcd", 16'h0004, 16'(rc_c));
      chk("col", 16'h000B, 16'(col_b));
      wr(ADDR_BUS_CONFIG, 16'h0001);
      cyc(1);
      chk("rcd_ext", 16'h0000, 16'(rc_c));
      wr(ADDR_BUS_CONFIG, 16'h0000);
      wr(ADDR_AREA2_DRAM_CONTROL, 16'h0300);
      wr(ADDR_REFRESH_TIMER_CSR, 16'h0042);
      rd(ADDR_REFRESH_TIMER_CSR, 16'h0000, "csr_nokey");
      wr(ADDR_REFRESH_TIMER_CSR, 16'hA542);
      rd(ADDR_REFRESH_TIMER_CSR, 16'h0042, "csr_key");
      wr(ADDR_REFRESH_TIME_CONSTANT, 16'hA502);
      wr(ADDR_REFRESH_TIMER_CSR, 16'hA548);
      wait_hi(timer_irq, 100, "irq");
      wr(ADDR_REFRESH_TIMER_CSR, 16'hA508);
   endtask
   task automatic t_pc();
      logic [5:0] bw;
      for (int w = 0; w < 16; w++) begin
         wr(ADDR_PC_CARD_WAIT_LOW, {10'h000, w[2:0], w[2:0]});
         wr(ADDR_PC_CARD_TIMING, {w[3], w[3], 14'h0000});
         cyc(1);
         bw = (w == 0) ? 6'h02 : wait_tab[w] + 6'h01;
         chk("first5", 16'(wait_tab[w]), 16'(f5));
         chk("first6", 16'(wait_tab[w]), 16'(f6));
         chk("burst5", 16'(bw), 16'(b5));
         chk("burst6", 16'(bw), 16'(b6));
      end
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_PC_CARD_TIMING,
            {4'h0, c[2], 2'b00, c[2], c[1:0], 4'h0, c[1:0]});
         cyc(1);
         chk("lead5", 16'(2 * c + 1), 16'(l5));
         chk("trail6", 16'(2 * c + 1), 16'(t6));
         chk("lead6", 16'h0001, 16'(l6));
         chk("trail5", 16'h0001, 16'(t5));
      end
   endtask
   task automatic t_row();
      int e;
      for (int c = 0; c < 8; c++) begin
         e = (c == 1 || c == 5) ? 1 : (c == 2 || c == 7) ? 2 : 0;
         wr(ADDR_MEMORY_CONTROL, 16'(c << 3));
         @(posedge clk);
         row_source_bits <= 3'(1 << e);
         cyc(2);
         chk("row_a1", 16'h0001, 16'(row_a1));
         @(posedge clk);
         row_source_bits <= ~3'(1 << e);
         cyc(2);
         chk("row_a1", 16'h0000, 16'(row_a1));
      end
      wr(ADDR_MEMORY_CONTROL, 16'h0001);
      @(posedge clk);
      area2_is_dram <= 1'b1;
      cyc(2);
      chk("edo", 16'h0003,
         {14'h0000, sample_on_rise, ras_negate_late});
      chk("bus16", 16'h0001, 16'(area2_bus16));
      wr(ADDR_MEMORY_CONTROL, 16'h0000);
      wr(ADDR_BUS_CONFIG, 16'h0002);
      wr(16'h18C0, 16'h0000);
      chk("mode32", 16'h1230, {3'h0, mode_write, mode_value});
      wr(ADDR_BUS_CONFIG, 16'h0000);
      wr(16'h18C0, 16'h0000);
      chk("mode16", 16'h1460, {3'h0, mode_write, mode_value});
   endtask
   task automatic t_refresh();
      int n;
      quiet(40, "ras_off");
      pulse(1'b0);
      wr(ADDR_MEMORY_CONTROL, 16'h0004);
      wait_hi(refresh_ras, 200, "ras");
      chk("term", 16'h0001, 16'(bus_terminate));
      for (n = 0; n < 10 && refresh_ras === 1'b1; n++) cyc(1);
      chk("ras_len", 16'h0005, 16'(n));
      chk("cut", 16'h0000, 16'(bus_cycle_active));
      wr(ADDR_REFRESH_TIMER_CSR, 16'hA508);
      wait_hi(refresh_ras, 40, "ras2");
      rd(ADDR_REFRESH_TIMER_CSR, 16'h0008, "flag_clear");
      wr(ADDR_MEMORY_CONTROL, 16'h0000);
      pulse(1'b0);
      wr(ADDR_MEMORY_CONTROL, 16'h0006);
      cyc(10);
      chk("self_wait", 16'h0000, 16'(self_refresh));
      pulse(1'b1);
      wait_hi(self_refresh, 10, "self");
      quiet(60, "ras_self");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_regs();
      t_pc();
      t_row();
      t_refresh();
      final_report();
   end
endmodule
